// *** design/bus_cycle_timing_arbiter.sv ***
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/100ps
module bus_cycle_timing_arbiter
  import bus_timing_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [AXI_ADDR_W-1:0] awaddr,
  input  wire logic [2:0]            awprot,
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [DATA_W-1:0]     wdata,
  input  wire logic [3:0]            wstrb,
  input  wire logic                  wvalid,
  output logic                       wready,
  output logic [1:0]                 bresp,
  output logic                       bvalid,
  input  wire logic                  bready,
  input  wire logic [AXI_ADDR_W-1:0] araddr,
  input  wire logic [2:0]            arprot,
  input  wire logic                  arvalid,
  output logic                       arready,
  output logic [DATA_W-1:0]          rdata,
  output logic [1:0]                 rresp,
  output logic                       rvalid,
  input  wire logic                  rready,
  input  wire logic                  ext_bus_request_n,
  input  wire logic                  ext_wait_n,
  input  wire logic [2:0]            boot_mode_pins,
  input  wire logic                  refresh_req,
  input  wire logic                  dma_req,
  input  wire logic [2:0]            dma_area,
  input  wire logic                  dma_a27,
  input  wire logic                  dma_write,
  input  wire logic                  cpu_req,
  input  wire logic [2:0]            cpu_area,
  input  wire logic                  cpu_a27,
  input  wire logic                  cpu_write,
  input  wire logic                  cpu_lock,
  output logic                       bus_ack_n,
  output logic                       bus_drive_en,
  output logic                       cpu_grant,
  output logic                       dma_grant,
  output logic                       refresh_grant,
  output logic                       cycle_done
);
  logic [15:0]           wait_ctrl_first, wait_ctrl_second;
  logic [5:0]            long_wait_count_reg;
  logic [1:0]            bus_mode, ext_bus_request_n_sync, wait_sync;
  logic [2:0]            boot_meta, boot_mode, sel_area;
  arb_state_t            state;
  owner_t                cur_owner, pick;
  logic                  ext_bus_request_n_low, cur_lock, no_release, boundary, release_ok, ext_pending;
  logic                  lock_only, ref_ok, dma_ok, cpu_ok, launch;
  logic                  sel_a27, sel_write, sel_rd_bit, aw_got, w_got, wr_fire;
  logic [4:0]            sel_timing;
  logic [AXI_ADDR_W-1:0] waddr;
  logic [DATA_W-1:0]     wdata_q;
  logic [3:0]            wstrb_q;
  state_timer_if tif ();
  state_timer u_timer (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .wait_low (!wait_sync[1]),
    .tif      (tif.timer)
  );
  // Pins are asynchronous; first stage feeds only the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_bus_request_n_sync <= 2'h3;
      wait_sync <= 2'h3;
      boot_meta <= 3'h0;
      boot_mode <= 3'h0;
    end else begin
      ext_bus_request_n_sync <= {ext_bus_request_n_sync[0], ext_bus_request_n};
      wait_sync <= {wait_sync[0], ext_wait_n};
      boot_meta <= boot_mode_pins;
      boot_mode <= boot_meta;
    end
  end
  assign ext_bus_request_n_low = !ext_bus_request_n_sync[1];
  function automatic logic [4:0] cycle_timing(input logic [2:0] area, input logic a27,
                                              input logic wr, input logic rd_bit);
    logic [1:0] lf;
    logic [3:0] lw;
    logic       pitch;
    lf = long_wait_count_reg[LW_AREA6_POS +: 2];
    if (area == AREA0) lf = long_wait_count_reg[LW_AREA0_POS +: 2];
    if (area == AREA2) lf = long_wait_count_reg[LW_AREA2_POS +: 2];
    lw    = ST_TWO + {2'h0, lf};
    pitch = wr ? wait_ctrl_first[WW_POS] : rd_bit;
    if (area == AREA5 && a27) begin
      cycle_timing = {1'b0, ST_THREE};
    end else if ((area == AREA7 && !a27) || (area == AREA0 && boot_mode == BOOT_ONCHIP_ROM)) begin
      cycle_timing = {1'b0, ST_ONE};
    end else if (area == AREA6 && !a27 && bus_mode[MODE_MUX_POS]) begin
      cycle_timing = {1'b1, ST_FOUR};
    end else if (area == AREA1 && bus_mode[MODE_DRAM_POS]) begin
      cycle_timing = pitch ? {1'b1, ST_TWO} : {1'b0, ST_ONE};
    end else if (area == AREA0 || area == AREA2 || area == AREA6) begin
      cycle_timing = {wr | rd_bit, lw};
    end else if (wr || rd_bit) begin
      cycle_timing = {1'b1, ST_TWO};
    end else begin
      cycle_timing = {1'b0, ST_ONE};
    end
  endfunction

  // Arbitration happens only at a cycle boundary
  always_comb begin
    boundary    = (state == ARB_IDLE) || (state == ARB_CYCLE && tif.done);
    // Request read in the cycle's last state; later ones wait a cycle
    release_ok  = !no_release &&
                  !(state == ARB_CYCLE && (cur_lock || cur_owner == OWN_REFRESH));
    ext_pending = ext_bus_request_n_low && release_ok;
    lock_only   = no_release && cur_lock;
    ref_ok      = refresh_req && !refresh_grant && !lock_only;
    dma_ok      = dma_req && !dma_grant && !lock_only;
    cpu_ok      = cpu_req && !cpu_grant;
    launch      = boundary && !ext_pending && (ref_ok || dma_ok || cpu_ok);
    if (ref_ok) begin
      pick = OWN_REFRESH;
    end else if (dma_ok) begin
      pick = OWN_DMA;
    end else if (cpu_ok) begin
      pick = OWN_CPU;
    end else begin
      pick = OWN_NONE;
    end
    sel_area   = (pick == OWN_DMA) ? dma_area  : cpu_area;
    sel_a27    = (pick == OWN_DMA) ? dma_a27   : cpu_a27;
    sel_write  = (pick == OWN_DMA) ? dma_write : cpu_write;
    sel_rd_bit = (pick == OWN_DMA) ? wait_ctrl_second[sel_area] : wait_ctrl_first[sel_area];
    sel_timing = cycle_timing(sel_area, sel_a27, sel_write, sel_rd_bit);
    tif.start  = launch && (state != ARB_RELEASED);
    tif.base   = (pick == OWN_REFRESH) ? REFRESH_STATES : sel_timing[3:0];
    tif.wait_en = (pick != OWN_REFRESH) && sel_timing[4];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ARB_IDLE;
    end else begin
      case (state)
        ARB_IDLE: begin
          if (ext_pending) begin
            state <= ARB_RELEASED;
          end else if (launch) begin
            state <= ARB_CYCLE;
          end
        end
        ARB_CYCLE: begin
          if (tif.done) begin
            if (ext_pending) begin
              state <= ARB_RELEASED;
            end else if (!launch) begin
              state <= ARB_IDLE;
            end
          end
        end
        ARB_RELEASED: begin
          if (!ext_bus_request_n_low) begin
            state <= ARB_IDLE;
          end
        end
        default: state <= ARB_IDLE;
      endcase
    end
  end

  // Output drive follows ownership; acknowledge also goes high on a refresh request while released
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus_ack_n    <= 1'b1;
      bus_drive_en <= 1'b1;
    end else if (state != ARB_RELEASED && boundary && ext_pending) begin
      bus_ack_n    <= refresh_req;
      bus_drive_en <= 1'b0;
    end else if (state == ARB_RELEASED) begin
      if (!ext_bus_request_n_low) begin
        bus_ack_n    <= 1'b1;
        bus_drive_en <= 1'b1;
      end else if (refresh_req) begin
        bus_ack_n <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur_owner     <= OWN_NONE;
      cur_lock      <= 1'b0;
      no_release    <= 1'b0;
      cpu_grant     <= 1'b0;
      dma_grant     <= 1'b0;
      refresh_grant <= 1'b0;
      cycle_done    <= 1'b0;
    end else begin
      cpu_grant     <= tif.start && pick == OWN_CPU;
      dma_grant     <= tif.start && pick == OWN_DMA;
      refresh_grant <= tif.start && pick == OWN_REFRESH;
      cycle_done    <= state == ARB_CYCLE && tif.done;
      if (tif.start) begin
        cur_owner <= pick;
        cur_lock  <= (pick == OWN_CPU) && cpu_lock;
      end
      if (state == ARB_CYCLE && tif.done) begin
        no_release <= cur_lock || (cur_owner == OWN_REFRESH && launch);
      end
    end
  end

  // Register bus: one write and one read in flight
  assign wr_fire = aw_got && w_got && !bvalid;

  function automatic logic addr_mapped(input logic [AXI_ADDR_W-1:0] a);
    addr_mapped = (a == OFF_WAIT_CTRL_FIRST) || (a == OFF_WAIT_CTRL_SECOND) ||
                  (a == OFF_LONG_WAIT) || (a == OFF_BUS_MODE) || (a == OFF_STATUS);
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready  <= 1'b1;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
      aw_got  <= 1'b0;
      w_got   <= 1'b0;
      waddr   <= '0;
      wdata_q <= '0;
      wstrb_q <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        waddr   <= awaddr;
        awready <= 1'b0;
        aw_got  <= 1'b1;
      end
      if (wvalid && wready) begin
        wdata_q <= wdata;
        wstrb_q <= wstrb;
        wready  <= 1'b0;
        w_got   <= 1'b1;
      end
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp  <= (addr_mapped(waddr) && waddr != OFF_STATUS) ? RESP_OKAY : RESP_SLVERR;
        aw_got <= 1'b0;
        w_got  <= 1'b0;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wait_ctrl_first     <= RST_WAIT_CTRL_FIRST;
      wait_ctrl_second    <= RST_WAIT_CTRL_SECOND;
      long_wait_count_reg <= RST_LONG_WAIT;
      bus_mode            <= RST_BUS_MODE;
    end else if (wr_fire) begin
      case (waddr)
        OFF_WAIT_CTRL_FIRST: begin
          if (wstrb_q[0]) wait_ctrl_first[7:0] <= wdata_q[7:0];
          if (wstrb_q[1]) wait_ctrl_first[15:8] <= wdata_q[15:8] & 8'h02;
        end
        OFF_WAIT_CTRL_SECOND: begin
          if (wstrb_q[0]) wait_ctrl_second[7:0] <= wdata_q[7:0];
        end
        OFF_LONG_WAIT: begin
          if (wstrb_q[0]) long_wait_count_reg <= wdata_q[5:0];
        end
        OFF_BUS_MODE: begin
          if (wstrb_q[0]) bus_mode <= wdata_q[1:0];
        end
        default: bus_mode <= bus_mode;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rresp   <= addr_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      case (araddr)
        OFF_WAIT_CTRL_FIRST:  rdata <= {16'h0000, wait_ctrl_first};
        OFF_WAIT_CTRL_SECOND: rdata <= {16'h0000, wait_ctrl_second};
        OFF_LONG_WAIT:        rdata <= {26'h0000000, long_wait_count_reg};
        OFF_BUS_MODE:         rdata <= {30'h00000000, bus_mode};
        OFF_STATUS:           rdata <= {22'h000000, boot_mode, no_release, cur_owner,
                                        state, bus_drive_en, bus_ack_n};
        default:              rdata <= 32'h00000000;
      endcase
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  ack_floats_a: assert property (!bus_ack_n |-> !bus_drive_en)
    else $error("acknowledged while still driving");
  no_start_rel_a: assert property (!bus_drive_en
      |-> !cpu_grant && !dma_grant && !refresh_grant)
    else $error("cycle started while released");
  periph_three_a: assert property (tif.start && pick != OWN_REFRESH && sel_area == AREA5
      && sel_a27 |-> tif.base == ST_THREE && !tif.wait_en)
    else $error("peripheral cycle not 3 states");
  mux_four_a: assert property (tif.start && pick != OWN_REFRESH && sel_area == AREA6
      && !sel_a27 && bus_mode[MODE_MUX_POS] |-> tif.base == ST_FOUR && tif.wait_en)
    else $error("multiplexed cycle not 4 states");
  ext_first_a: assert property (boundary && ext_pending && state != ARB_RELEASED
      |=> state == ARB_RELEASED && !bus_drive_en)
    else $error("external request not served first");
  refresh_ack_a: assert property (state == ARB_RELEASED && refresh_req && ext_bus_request_n_low
      |=> bus_ack_n && state == ARB_RELEASED)
    else $error("refresh not signalled while released");
  refresh_back_a: assert property (state == ARB_RELEASED && !ext_bus_request_n_low && refresh_req
      && !dma_req && !cpu_req ##1 refresh_req && !ext_bus_request_n_low |=> refresh_grant)
    else $error("refresh not first after return");
  lock_hold_a: assert property (state == ARB_CYCLE && tif.done && cur_lock
      |-> !ext_pending ##1 no_release)
    else $error("bus released inside test-and-set");
  refresh_follow_a: assert property (state == ARB_CYCLE && tif.done
      && cur_owner == OWN_REFRESH |-> !ext_pending)
    else $error("bus released after refresh");
  dma_over_cpu_a: assert property (tif.start && dma_ok && !ref_ok |=> dma_grant && !cpu_grant)
    else $error("dma lost to cpu");

  release_c: cover property (state == ARB_CYCLE ##1 state == ARB_RELEASED);
  refresh_rel_c: cover property (state == ARB_RELEASED && refresh_req ##1 state == ARB_IDLE);
  lock_pair_c: cover property (cycle_done && cur_lock ##[1:4] cpu_grant);
  dram_long_c: cover property (tif.start && tif.base == ST_TWO && tif.wait_en);
endmodule

// *** design/bus_timing_pkg.sv ***
package bus_timing_pkg;
  localparam int         AXI_ADDR_W           = 5;
  localparam int         DATA_W               = 32;
  localparam logic [4:0] OFF_WAIT_CTRL_FIRST  = 5'h00;
  localparam logic [4:0] OFF_WAIT_CTRL_SECOND = 5'h04;
  localparam logic [4:0] OFF_LONG_WAIT        = 5'h08;
  localparam logic [4:0] OFF_BUS_MODE         = 5'h0C;
  localparam logic [4:0] OFF_STATUS           = 5'h10;
  localparam logic [15:0] RST_WAIT_CTRL_FIRST  = 16'h02FF;
  localparam logic [15:0] RST_WAIT_CTRL_SECOND = 16'h00FF;
  localparam logic [5:0]  RST_LONG_WAIT        = 6'h3F;
  localparam logic [1:0]  RST_BUS_MODE         = 2'h0;
  localparam int         WW_POS        = 9;
  localparam int         LW_AREA0_POS  = 0;
  localparam int         LW_AREA2_POS  = 2;
  localparam int         LW_AREA6_POS  = 4;
  localparam int         MODE_DRAM_POS = 0;
  localparam int         MODE_MUX_POS  = 1;
  localparam int         STATE_W        = 4;
  localparam logic [3:0] ST_ONE         = 4'h1;
  localparam logic [3:0] ST_TWO         = 4'h2;
  localparam logic [3:0] ST_THREE       = 4'h3;
  localparam logic [3:0] ST_FOUR        = 4'h4;
  localparam logic [3:0] REFRESH_STATES = 4'h2;
  localparam logic [2:0] BOOT_ONCHIP_ROM = 3'h2;
  localparam logic [2:0] AREA0 = 3'h0;
  localparam logic [2:0] AREA1 = 3'h1;
  localparam logic [2:0] AREA2 = 3'h2;
  localparam logic [2:0] AREA5 = 3'h5;
  localparam logic [2:0] AREA6 = 3'h6;
  localparam logic [2:0] AREA7 = 3'h7;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ARB_IDLE     = 2'b00,
    ARB_CYCLE    = 2'b01,
    ARB_RELEASED = 2'b10
  } arb_state_t;

  typedef enum logic [1:0] {
    OWN_NONE    = 2'b00,
    OWN_CPU     = 2'b01,
    OWN_DMA     = 2'b10,
    OWN_REFRESH = 2'b11
  } owner_t;
endpackage

// *** design/state_timer_if.sv ***
`timescale 1ns/100ps
interface state_timer_if;
  import bus_timing_pkg::*;
  logic               start;
  logic [STATE_W-1:0] base;
  logic               wait_en;
  logic               final_st;
  logic               done;
  logic               busy;
  modport timer (input start, base, wait_en, output final_st, done, busy);
  modport ctrl  (output start, base, wait_en, input final_st, done, busy);
endinterface

// *** design/state_timer.sv ***
`timescale 1ns/100ps
module state_timer
  import bus_timing_pkg::*;
(
  input wire logic    aclk,
  input wire logic    aresetn,
  input wire logic    wait_low,
  state_timer_if.timer tif
);
  logic [STATE_W-1:0] remaining;
  logic               busy;
  logic               wait_en_q;

  assign tif.busy     = busy;
  assign tif.final_st = busy && (remaining == ST_ONE);
  // Each sampled wait in the final state holds it one more state
  assign tif.done     = tif.final_st && !(wait_en_q && wait_low);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy      <= 1'b0;
      remaining <= 4'h0;
      wait_en_q <= 1'b0;
    end else if (tif.start) begin
      busy      <= 1'b1;
      remaining <= tif.base;
      wait_en_q <= tif.wait_en;
    end else if (tif.done) begin
      busy <= 1'b0;
    end else if (busy && remaining != ST_ONE) begin
      remaining <= remaining - ST_ONE;
    end
  end

  wait_extends_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tif.final_st && wait_en_q && wait_low && !tif.start |=> tif.final_st)
    else $error("wait state not inserted");
  wait_ignored_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tif.final_st && !wait_en_q |-> tif.done)
    else $error("wait sampled while ignored");
endmodule

// *** tb/ext_master_model.sv ***
`timescale 1ns/100ps
module ext_master_model #(
  parameter int TIMEOUT = 64
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic want_bus,
  input  wire logic bus_ack_n,
  output logic      ext_bus_request_n
);
  logic       ack_q;
  logic       seen_low;
  logic       given_up;
  logic [7:0] timer;

  // One capture flop; only this copy fans out, so a spike is seen once
  always_ff @(posedge aclk) begin
    ack_q <= bus_ack_n;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !want_bus) begin
      ext_bus_request_n <= 1'b1;
      seen_low          <= 1'b0;
      given_up          <= 1'b0;
      timer             <= 8'h00;
    end else if (!given_up) begin
      ext_bus_request_n <= 1'b0;
      timer             <= timer + 8'h01;
      if (!ack_q) begin
        seen_low <= 1'b1;
      end
      // Hand back at once on a refresh notice, or when release never shows
      if ((seen_low && ack_q) || (!seen_low && timer == TIMEOUT[7:0])) begin
        ext_bus_request_n <= 1'b1;
        given_up          <= 1'b1;
      end
    end
  end
endmodule

// *** tb/bus_cycle_timing_arbiter_test.sv ***
`timescale 1ns/100ps
module bus_cycle_timing_arbiter_test;
  import bus_timing_pkg::*;
  logic                  aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic                  arvalid, arready, rvalid, rready, ext_bus_request_n, ext_wait_n;
  logic                  refresh_req, dma_req, dma_a27, dma_write, cpu_req, cpu_a27;
  logic                  cpu_write, cpu_lock, want_bus, bus_ack_n, bus_drive_en;
  logic                  cpu_grant, dma_grant, refresh_grant, cycle_done;
  logic [AXI_ADDR_W-1:0] awaddr, araddr;
  logic [2:0]            awprot, arprot, boot_mode_pins, dma_area, cpu_area, g;
  logic [DATA_W-1:0]     wdata, rdata;
  logic [3:0]            wstrb;
  logic [1:0]            bresp, rresp;
  int                    err_count = 0;
  int                    checks_done = 0;
  int                    cycles = 0;
  int                    n;

  bus_cycle_timing_arbiter dut_u (
    .aclk, .aresetn, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .ext_bus_request_n, .ext_wait_n, .boot_mode_pins,
    .refresh_req, .dma_req, .dma_area, .dma_a27, .dma_write, .cpu_req, .cpu_area,
    .cpu_a27, .cpu_write, .cpu_lock, .bus_ack_n, .bus_drive_en, .cpu_grant,
    .dma_grant, .refresh_grant, .cycle_done
  );
  ext_master_model #(.TIMEOUT(64)) peer_u (
    .aclk, .aresetn, .want_bus, .bus_ack_n, .ext_bus_request_n
  );

  always #10 aclk = ~aclk;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      final_report();
    end
  end

  task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    check("bresp", bresp, er);
  endtask

  task automatic axi_rd(input logic [4:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    if (!$isunknown(ed)) check("rdata", rdata, ed);
    check("rresp", rresp, er);
  endtask

  task automatic wait_grant();
    g = 3'b000;
    for (int i = 0; i < 300 && g == 3'b000; i++) begin
      @(posedge aclk);
      g = {refresh_grant, dma_grant, cpu_grant};
    end
  endtask

  task automatic wait_ack(input logic v);
    n = 0;
    while (n < 300 && bus_ack_n !== v) begin
      @(posedge aclk);
      n++;
    end
    check("ack wait", n < 300, 1);
  endtask

  // States counted from the grant pulse to the done pulse; hold releases a held wait
  task automatic run(input logic [2:0] ar, input logic a27, input logic wr, input int hold,
                     input int exp);
    @(posedge aclk);
    cpu_area  <= ar;
    cpu_a27   <= a27;
    cpu_write <= wr;
    cpu_req   <= 1'b1;
    wait_grant();
    cpu_req <= 1'b0;
    n = 0;
    while (n < 300 && cycle_done !== 1'b1) begin
      @(posedge aclk);
      n++;
      if (n == hold) ext_wait_n <= 1'b1;
    end
    if (hold > 0) check("waited", n > hold, 1);
    else check("states", n, exp);
  endtask

  task automatic cfg(input logic [31:0] w1, input logic [31:0] lw, input logic [31:0] md);
    axi_wr(OFF_WAIT_CTRL_FIRST, w1, RESP_OKAY);
    axi_wr(OFF_LONG_WAIT, lw, RESP_OKAY);
    axi_wr(OFF_BUS_MODE, md, RESP_OKAY);
  endtask

  task automatic test_regs();
    check("drive", bus_drive_en, 1'b1);
    check("handshake idle", {awready, wready, arready, bvalid, rvalid}, 5'b11100);
    axi_rd(OFF_STATUS, 32'h00000003, RESP_OKAY);
    axi_rd(OFF_WAIT_CTRL_FIRST, 32'h000002FF, RESP_OKAY);
    axi_rd(OFF_WAIT_CTRL_SECOND, 32'h000000FF, RESP_OKAY);
    axi_rd(OFF_LONG_WAIT, 32'h0000003F, RESP_OKAY);
    axi_rd(OFF_BUS_MODE, 32'h00000000, RESP_OKAY);
    axi_rd(5'h14, 32'h00000000, RESP_SLVERR);
    axi_wr(5'h18, 32'h00000001, RESP_SLVERR);
    axi_wr(OFF_STATUS, 32'h00000000, RESP_SLVERR);
    axi_rd(OFF_BUS_MODE, 32'h00000000, RESP_OKAY);
  endtask

  task automatic test_timing();
    run(3'h3, 1'b0, 1'b0, 0, 2);
    run(AREA0, 1'b0, 1'b0, 0, 5);
    run(3'h3, 1'b0, 1'b1, 0, 2);
    run(AREA2, 1'b0, 1'b1, 0, 5);
    ext_wait_n <= 1'b0;
    run(AREA5, 1'b1, 1'b0, 0, 3);
    run(AREA7, 1'b0, 1'b1, 0, 1);
    run(3'h3, 1'b0, 1'b0, 6, 0);
    cfg(32'h00000000, 32'h00000024, 32'h00000000);
    ext_wait_n <= 1'b0;
    run(3'h3, 1'b0, 1'b0, 0, 1);
    run(AREA0, 1'b0, 1'b0, 0, 2);
    ext_wait_n <= 1'b1;
    run(AREA2, 1'b0, 1'b1, 0, 3);
    run(AREA6, 1'b0, 1'b0, 0, 4);
    cfg(32'h00000000, 32'h00000024, 32'h00000003);
    ext_wait_n <= 1'b0;
    run(AREA1, 1'b0, 1'b0, 0, 1);
    run(AREA1, 1'b0, 1'b1, 0, 1);
    ext_wait_n <= 1'b1;
    run(AREA6, 1'b0, 1'b1, 0, 4);
    run(AREA6, 1'b0, 1'b0, 0, 4);
    cfg(32'h00000202, 32'h00000024, 32'h00000003);
    run(AREA1, 1'b0, 1'b1, 0, 2);
    run(AREA1, 1'b0, 1'b0, 0, 2);
    boot_mode_pins <= BOOT_ONCHIP_ROM;
    ext_wait_n     <= 1'b0;
    repeat (4) @(posedge aclk);
    run(AREA0, 1'b0, 1'b0, 0, 1);
    ext_wait_n <= 1'b1;
  endtask

  task automatic test_priority();
    @(posedge aclk);
    cpu_req     <= 1'b1;
    dma_req     <= 1'b1;
    refresh_req <= 1'b1;
    wait_grant();
    check("first", g, 3'b100);
    refresh_req <= 1'b0;
    wait_grant();
    check("second", g, 3'b010);
    dma_req <= 1'b0;
    wait_grant();
    check("third", g, 3'b001);
    cpu_req <= 1'b0;
    repeat (10) @(posedge aclk);
  endtask

  task automatic test_release();
    @(posedge aclk);
    dma_req <= 1'b1;
    wait_grant();
    want_bus <= 1'b1;
    wait_ack(1'b0);
    check("drive off", bus_drive_en, 1'b0);
    axi_rd(OFF_STATUS, 32'h00000128, RESP_OKAY);
    g = 3'b000;
    repeat (10) begin
      @(posedge aclk);
      g |= {refresh_grant, dma_grant, cpu_grant};
    end
    check("quiet", g, 3'b000);
    // Refresh raised only once the release has settled
    refresh_req <= 1'b1;
    wait_ack(1'b1);
    check("held", bus_drive_en, 1'b0);
    wait_grant();
    check("refresh first", g, 3'b100);
    refresh_req <= 1'b0;
    want_bus    <= 1'b0;
    wait_grant();
    check("dma resumes", g, 3'b010);
    dma_req <= 1'b0;
    repeat (10) @(posedge aclk);
  endtask

  task automatic test_lock();
    @(posedge aclk);
    ext_wait_n <= 1'b0;
    cpu_area   <= AREA1;
    cpu_write  <= 1'b0;
    cpu_lock   <= 1'b1;
    cpu_req    <= 1'b1;
    wait_grant();
    cpu_lock  <= 1'b0;
    cpu_write <= 1'b1;
    want_bus  <= 1'b1;
    repeat (8) @(posedge aclk);
    ext_wait_n <= 1'b1;
    wait_grant();
    check("locked write", g, 3'b001);
    cpu_req <= 1'b0;
    wait_ack(1'b0);
    want_bus <= 1'b0;
    wait_ack(1'b1);
  endtask

  initial begin
    {aclk, aresetn, awaddr, awprot, awvalid, wdata, wvalid, bready, araddr, arprot, arvalid,
     rready, refresh_req, dma_req, dma_area, dma_a27, dma_write, cpu_req, cpu_area, cpu_a27,
     cpu_write, cpu_lock, want_bus, boot_mode_pins} = '0;
    ext_wait_n = 1'b1;
    wstrb      = 4'hF;
    dma_area   = 3'h3;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    test_regs();
    test_timing();
    test_priority();
    test_release();
    test_lock();
    final_report();
  end
endmodule
